// >>> bpc_baud_meas.sv
/*
 * Measures the bit period from the mode-select byte on the receive pin.
 * Assumes the pin idles high and is asynchronous to clk.
 */
`timescale 1ns/1ns
module bpc_baud_meas #(
    parameter int unsigned BIT_MAX = bpc_pkg::BIT_MAX_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic rxd_pin,
    output logic baud_done,
    output logic baud_fail,
    output logic [bpc_pkg::TMR_W-1:0] bit_period
);
    import bpc_pkg::*;

    localparam logic [TMR_W-1:0] T_MIN = TMR_W'(BIT_MIN_CYC);
    localparam logic [TMR_W-1:0] T_MAX = TMR_W'(BIT_MAX);
    localparam logic [TMR_W-1:0] T_LIMIT = TMR_W'(BIT_MAX * 10);

    logic s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
    logic [1:0] ecnt_r, ecnt_nxt;
    logic run_r, run_nxt, fin_r, fin_nxt, done_nxt, fail_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt, tab_r, tab_nxt, tac_r, tac_nxt, per_nxt;
    logic chg;
    logic [TMR_W+3:0] lhs, rhs;

    function automatic logic [TMR_W+3:0] adif(input logic [TMR_W+3:0] a,
                                               input logic [TMR_W+3:0] b);
        adif = (a > b) ? a - b : b - a;
    endfunction : adif

    ////////////////////////////////////////////////////////////////////////
    // A level change counts only once the second and third stages agree.
    assign chg = (s2_r == s3_r) && (s3_r != lvl_r);
    // The last rising edge of the byte must sit eight bit times after the start edge, within one bit time.
    assign lhs = {2'b00, tmr_r, 2'b00};
    assign rhs = {1'b0, tac_r, 3'b000};

    // Edges A, B, C, D of the byte give two, four and eight bit times.
    always_comb begin
        lvl_nxt = chg ? s3_r : lvl_r;
        ecnt_nxt = ecnt_r;
        run_nxt = run_r;
        fin_nxt = fin_r;
        tmr_nxt = run_r ? tmr_r + 1'b1 : tmr_r;
        tab_nxt = tab_r;
        tac_nxt = tac_r;
        per_nxt = bit_period;
        done_nxt = 1'b0;
        fail_nxt = 1'b0;
        if (!fin_r && chg) begin
            if (!run_r) begin
                if (!s3_r) begin
                    run_nxt = 1'b1;
                    tmr_nxt = TMR_W'(1); // Counts whole clocks, so T bits read as T.
                end
            end else begin
                ecnt_nxt = ecnt_r + 1'b1;
                case (ecnt_r)
                    2'd0: tab_nxt = tmr_r;
                    2'd1: tac_nxt = tmr_r;
                    default: begin
                        run_nxt = 1'b0;
                        fin_nxt = 1'b1;
                        per_nxt = tac_r >> 2;
                        if ((tac_r >> 2) >= T_MIN && (tac_r >> 2) <= T_MAX
                            && adif({3'b000, tab_r, 1'b0}, (TMR_W+4)'(tac_r))
                               <= (TMR_W+4)'(tac_r >> 3)
                            && adif(lhs, rhs) <= (TMR_W+4)'(tac_r)) begin
                            done_nxt = 1'b1;
                        end else begin
                            fail_nxt = 1'b1;
                        end
                    end
                endcase
            end
        end else if (!fin_r && run_r && tmr_r >= T_LIMIT) begin
            run_nxt = 1'b0;
            fin_nxt = 1'b1;
            fail_nxt = 1'b1;
        end
    end

    // Register stage, including the three-stage pin synchroniser.
    always_ff @(posedge clk) begin
        s1_r <= rxd_pin;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (srst) begin
            lvl_r <= 1'b1;
            ecnt_r <= 2'd0;
            run_r <= 1'b0;
            fin_r <= 1'b0;
            tmr_r <= '0;
            tab_r <= '0;
            tac_r <= '0;
            bit_period <= '0;
            baud_done <= 1'b0;
            baud_fail <= 1'b0;
        end else begin
            lvl_r <= lvl_nxt;
            ecnt_r <= ecnt_nxt;
            run_r <= run_nxt;
            fin_r <= fin_nxt;
            tmr_r <= tmr_nxt;
            tab_r <= tab_nxt;
            tac_r <= tac_nxt;
            bit_period <= per_nxt;
            baud_done <= done_nxt;
            baud_fail <= fail_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_BAUD_RANGE: assert property (baud_done
            |-> bit_period >= T_MIN && bit_period <= T_MAX)
        else $error("Accepted bit period outside the supported range.");
    AST_ONE_VERDICT: assert property ((baud_done || baud_fail)
            |=> !(baud_done || baud_fail)[*8])
        else $error("Baud verdict given more than once.");

endmodule : bpc_baud_meas

// >>> bpc_boot_front.sv
/*
 * Serial boot front end: baud detection, command echo, password check,
 * flash SUM with check byte, and user boot mode selection after reset.
 * Assumes a byte UART on the same clock, driven with bit_period, and a
 * flash read port answering one read at a time.
 */
`timescale 1ns/1ns
module bpc_boot_front #(
    parameter int unsigned BIT_MAX = bpc_pkg::BIT_MAX_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic rxd_pin,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_err,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic [bpc_pkg::TMR_W-1:0] bit_period,
    output logic baud_locked,
    output logic halted,
    output logic fl_rd_req,
    output logic [23:0] fl_addr,
    input wire logic fl_rd_valid,
    input wire logic [7:0] fl_rdata,
    input wire logic boot_pin,
    input wire logic flash_busy,
    output logic user_boot,
    output logic irq_hold,
    output logic ram_exec
);
    import bpc_pkg::*;

    bpc_state_t st_r, st_nxt, ret_r, ret_nxt;
    logic [7:0] tx_nxt, cmd_r, cmd_nxt, ck_r, ck_nxt;
    logic [3:0] hi_r, hi_nxt, idx_r, idx_nxt;
    logic [15:0] sum_r, sum_nxt;
    logic [16:0] cnt_r, cnt_nxt;
    logic [23:0] addr_nxt;
    logic mism_r, mism_nxt, rxe_r, rxe_nxt;
    logic [7:0] pw_mem [0:14];
    logic pw_we;
    logic baud_done, baud_fail, lock_nxt, halt_nxt;
    logic pw_same, pw_blank, pw_err;
    logic rx_take, tx_take;

    ////////////////////////////////////////////////////////////////////////
    // The timing of the first byte is measured here, not received.
    bpc_baud_meas #(.BIT_MAX(BIT_MAX)) u_baud (
        .clk(clk),
        .srst(srst),
        .rxd_pin(rxd_pin),
        .baud_done(baud_done),
        .baud_fail(baud_fail),
        .bit_period(bit_period)
    );

    // Handshakes follow the state directly.
    assign rx_ready = (st_r == ST_CMD) || (st_r == ST_PWRX);
    assign tx_valid = (st_r == ST_SEND);
    assign fl_rd_req = (st_r == ST_PWRD) || (st_r == ST_SUMRD);
    assign rx_take = rx_valid && rx_ready;
    assign tx_take = tx_valid && tx_ready;

    // Password verdict; identical password bytes are a weak password unless all 15 stored bytes are blank.
    always_comb begin
        pw_same = 1'b1;
        pw_blank = 1'b1;
        for (int i = 0; i < 15; i++) begin
            if (i < 12 && pw_mem[i] != pw_mem[0]) begin
                pw_same = 1'b0;
            end
            if (pw_mem[i] != BLANK) begin
                pw_blank = 1'b0;
            end
        end
        pw_err = mism_r || (pw_same && !pw_blank);
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer next state.
    always_comb begin
        st_nxt = st_r;
        ret_nxt = ret_r;
        tx_nxt = tx_data;
        cmd_nxt = cmd_r;
        hi_nxt = hi_r;
        idx_nxt = idx_r;
        ck_nxt = ck_r;
        sum_nxt = sum_r;
        cnt_nxt = cnt_r;
        addr_nxt = fl_addr;
        mism_nxt = mism_r;
        rxe_nxt = rxe_r;
        lock_nxt = baud_locked;
        halt_nxt = halted;
        pw_we = 1'b0;
        case (st_r)
            ST_BAUD: begin
                if (baud_done) begin
                    lock_nxt = 1'b1;
                    tx_nxt = MODE_SEL;
                    ret_nxt = ST_CMD;
                    st_nxt = ST_SEND;
                end else if (baud_fail) begin
                    halt_nxt = 1'b1;
                    st_nxt = ST_HALT;
                end
            end
            ST_HALT: st_nxt = ST_HALT;
            ST_CMD: begin
                if (rx_take) begin
                    st_nxt = ST_SEND;
                    ret_nxt = ST_CMD;
                    if (rx_err) begin
                        tx_nxt = {hi_r, ACK_RXERR};
                    end else if (rx_data == CMD_RAM || rx_data == CMD_PROT) begin
                        tx_nxt = rx_data;
                        cmd_nxt = rx_data;
                        hi_nxt = rx_data[7:4];
                        ret_nxt = ST_PWRD;
                        idx_nxt = '0;
                        addr_nxt = PW_BASE;
                    end else if (rx_data == CMD_SUM) begin
                        tx_nxt = rx_data;
                        cmd_nxt = rx_data;
                        hi_nxt = rx_data[7:4];
                        ret_nxt = ST_SUMRD;
                        sum_nxt = '0;
                        cnt_nxt = '0;
                        addr_nxt = FLASH_BASE;
                    end else if (rx_data == CMD_INFO || rx_data == CMD_ERASE) begin
                        tx_nxt = rx_data;
                        cmd_nxt = rx_data;
                        hi_nxt = rx_data[7:4];
                    end else begin
                        tx_nxt = {hi_r, ACK_BAD};
                    end
                end
            end
            ST_SEND: begin
                if (tx_take) begin
                    st_nxt = ret_r;
                end
            end
            ST_PWRD: begin
                if (fl_rd_valid) begin
                    pw_we = 1'b1;
                    idx_nxt = idx_r + 1'b1;
                    if (idx_r == PW_LEN + VEC_LEN - 1'b1) begin
                        idx_nxt = '0;
                        mism_nxt = 1'b0;
                        rxe_nxt = 1'b0;
                        ck_nxt = 8'h00;
                        st_nxt = ST_PWRX;
                    end else if (idx_r == PW_LEN - 1'b1) begin
                        addr_nxt = VEC_BASE;
                    end else begin
                        addr_nxt = fl_addr + 24'h000001;
                    end
                end
            end
            ST_PWRX: begin
                if (rx_take) begin
                    idx_nxt = idx_r + 1'b1;
                    ck_nxt = ck_add(ck_r, rx_data);
                    rxe_nxt = rxe_r || rx_err;
                    if (idx_r < PW_LEN && rx_data != pw_mem[idx_r]) begin
                        mism_nxt = 1'b1;
                    end
                    if (idx_r == PW_LEN) begin
                        st_nxt = ST_SEND;
                        ret_nxt = ST_CMD;
                        if (rxe_r || rx_err) begin
                            tx_nxt = {hi_r, ACK_RXERR};
                        end else if (ck_add(ck_r, rx_data) != 8'h00) begin
                            tx_nxt = {hi_r, ACK_BAD};
                        end else if (pw_err) begin
                            tx_nxt = {hi_r, ACK_BAD};
                        end else begin
                            tx_nxt = cmd_r;
                        end
                    end
                end
            end
            ST_SUMRD: begin
                if (fl_rd_valid) begin
                    sum_nxt = sum_r + {8'h00, fl_rdata};
                    cnt_nxt = cnt_r + 1'b1;
                    addr_nxt = fl_addr + 24'h000001;
                    if (cnt_r == FLASH_BYTES - 1'b1) begin
                        st_nxt = ST_SUMHI;
                    end
                end
            end
            ST_SUMHI: begin
                tx_nxt = sum_r[15:8];
                ret_nxt = ST_SUMLO;
                st_nxt = ST_SEND;
            end
            ST_SUMLO: begin
                tx_nxt = sum_r[7:0];
                ret_nxt = ST_SUMCK;
                st_nxt = ST_SEND;
            end
            ST_SUMCK: begin
                tx_nxt = ck_neg(ck_add(sum_r[15:8], sum_r[7:0]));
                ret_nxt = ST_CMD;
                st_nxt = ST_SEND;
            end
            default: st_nxt = ST_HALT;
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= ST_BAUD;
            ret_r <= ST_CMD;
            tx_data <= 8'h00;
            cmd_r <= 8'h00;
            hi_r <= CMD_HI_RST;
            idx_r <= 4'h0;
            ck_r <= 8'h00;
            sum_r <= 16'h0000;
            cnt_r <= 17'h00000;
            fl_addr <= 24'h000000;
            mism_r <= 1'b0;
            rxe_r <= 1'b0;
            baud_locked <= 1'b0;
            halted <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ret_r <= ret_nxt;
            tx_data <= tx_nxt;
            cmd_r <= cmd_nxt;
            hi_r <= hi_nxt;
            idx_r <= idx_nxt;
            ck_r <= ck_nxt;
            sum_r <= sum_nxt;
            cnt_r <= cnt_nxt;
            fl_addr <= addr_nxt;
            mism_r <= mism_nxt;
            rxe_r <= rxe_nxt;
            baud_locked <= lock_nxt;
            halted <= halt_nxt;
        end
    end

    // Stored password and reset vector copy; a reset leaves it as is.
    always_ff @(posedge clk) begin
        if (pw_we) begin
            pw_mem[idx_r] <= fl_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot mode select. The pin is caught only once the synchroniser has
    // settled after reset, so a stale pre-reset level cannot pick the mode.
    logic bs1_r, bs2_r, bs3_r;
    logic [1:0] set_r, set_nxt;
    logic ub_nxt, irq_nxt, ram_nxt;

    always_comb begin
        set_nxt = set_r;
        ub_nxt = user_boot;
        if (set_r != 2'(SYNC_SETTLE)) begin
            set_nxt = set_r + 1'b1;
            if (set_r == 2'(SYNC_SETTLE - 1) && bs2_r == bs3_r) begin
                ub_nxt = bs3_r;
            end
        end
        irq_nxt = user_boot && flash_busy;
        ram_nxt = flash_busy;
    end

    always_ff @(posedge clk) begin
        bs1_r <= boot_pin;
        bs2_r <= bs1_r;
        bs3_r <= bs2_r;
        if (srst) begin
            set_r <= 2'd0;
            user_boot <= 1'b0;
            irq_hold <= 1'b0;
            ram_exec <= 1'b0;
        end else begin
            set_r <= set_nxt;
            user_boot <= ub_nxt;
            irq_hold <= irq_nxt;
            ram_exec <= ram_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence seq_cmd_take(logic [7:0] c);
        st_r == ST_CMD && rx_take && !rx_err && rx_data == c;
    endsequence

    sequence seq_sum_done;
        st_r == ST_SUMRD && fl_rd_valid && cnt_r == FLASH_BYTES - 1'b1;
    endsequence

    AST_ECHO_PW: assert property ((seq_cmd_take(CMD_RAM) or seq_cmd_take(CMD_PROT))
            |=> st_r == ST_SEND && tx_data == $past(rx_data) && ret_r == ST_PWRD)
        else $error("Password command not echoed before verification.");
    AST_PW_START: assert property ((st_r == ST_SEND && ret_r == ST_PWRD && tx_take)
            |=> st_r == ST_PWRD && fl_addr == PW_BASE && fl_rd_req)
        else $error("Password read did not start at the password base.");
    AST_NO_RX_EARLY: assert property (st_r == ST_BAUD |-> !rx_ready && !tx_valid)
        else $error("Byte handshake active before baud detection finished.");
    AST_HALT_SILENT: assert property (halted |-> !tx_valid && !rx_ready)
        else $error("Transmit attempted after baud failure.");
    AST_RXERR_ACK: assert property ((st_r == ST_CMD && rx_take && rx_err)
            |=> tx_data == {$past(hi_r), ACK_RXERR})
        else $error("Receive error acknowledge malformed.");
    AST_BAD_NIBBLE: assert property ((st_r == ST_CMD && rx_take && !rx_err && rx_data[3:0] == 4'h5)
            |=> tx_data == {$past(hi_r), ACK_BAD})
        else $error("Unknown command acknowledge lost the command nibble.");
    AST_SUM_ORDER: assert property (seq_sum_done ##1 st_r == ST_SUMHI
            |=> st_r == ST_SEND && ret_r == ST_SUMLO && tx_data == sum_r[15:8])
        else $error("SUM high byte not sent first.");
    AST_SUM_CK: assert property (st_r == ST_SUMCK
            |=> tx_data == 8'h00 - 8'(sum_r[15:8] + sum_r[7:0]))
        else $error("SUM check byte wrong.");
    AST_PW_FLAG: assert property ((st_r == ST_PWRX && rx_take && idx_r == PW_LEN && !rx_err
            && !rxe_r && ck_add(ck_r, rx_data) == 8'h00)
            |=> tx_data[0] == $past(pw_err))
        else $error("Password verdict not reflected in acknowledge.");
    AST_WEAK_PW: assert property ((st_r == ST_PWRX && rx_take && idx_r == PW_LEN && !rx_err
            && !rxe_r && pw_same && !pw_blank) |=> tx_data[0])
        else $error("Identical password bytes accepted.");
    AST_IRQ_HOLD: assert property ((user_boot && flash_busy) |=> irq_hold && ram_exec)
        else $error("Interrupts not held during flash work.");

endmodule : bpc_boot_front

// >>> bpc_boot_front_tb.sv
/*
 * Self-checking bench of the boot front end: baud byte, password frames, acks.
 * Assumes the flash model below and a same-clock byte UART played by tasks.
 */
`timescale 1ns/1ns
module bpc_boot_front_tb;
    import bpc_pkg::*;
    localparam int T = 1200;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rxd_pin = 1'b1;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_err = 1'b0;
    logic tx_ready = 1'b0;
    logic boot_pin = 1'b1;
    logic flash_busy = 1'b0;
    logic rx_ready, tx_valid, baud_locked, halted, fl_rd_req, fl_rd_valid;
    logic user_boot, irq_hold, ram_exec;
    logic [7:0] tx_data, fl_rdata;
    logic [23:0] fl_addr;
    logic [TMR_W-1:0] bit_period;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;

    bpc_boot_front #(.BIT_MAX(1300)) dut_u (.clk(clk), .srst(srst), .rxd_pin(rxd_pin),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .bit_period(bit_period), .baud_locked(baud_locked), .halted(halted),
        .fl_rd_req(fl_rd_req), .fl_addr(fl_addr), .fl_rd_valid(fl_rd_valid),
        .fl_rdata(fl_rdata), .boot_pin(boot_pin), .flash_busy(flash_busy),
        .user_boot(user_boot), .irq_hold(irq_hold), .ram_exec(ram_exec));
    bpc_flash_model flash_u (.clk(clk), .fl_rd_req(fl_rd_req), .fl_addr(fl_addr),
        .fl_rd_valid(fl_rd_valid), .fl_rdata(fl_rdata));

    ////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling so a hang still reaches the verdict.
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp8

    // Waiting is judged at the falling edge, where outputs have settled.
    task automatic get_tx(input logic [7:0] exp);
        int n;
        n = 0;
        @(negedge clk);
        while (tx_valid !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (tx_valid !== 1'b1) err_total++;
        cmp8("tx_data", exp, tx_data);
        @(posedge clk) tx_ready <= 1'b1;
        @(posedge clk) tx_ready <= 1'b0;
    endtask : get_tx

    task automatic put_rx(input logic [7:0] b, input logic e);
        int n;
        n = 0;
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        rx_err <= e;
        @(negedge clk);
        while (rx_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (rx_ready !== 1'b1) err_total++;
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask : put_rx

    // Reset with the given boot condition, then the mode byte LSB first with a start bit.
    task automatic baud_run(input int t, input logic bp);
        logic [9:0] fr;
        fr = {1'b1, MODE_SEL, 1'b0};
        boot_pin <= bp;
        srst <= 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk) rxd_pin <= fr[i];
            repeat (t - 1) @(posedge clk);
        end
        if (t >= BIT_MIN_CYC) begin
            get_tx(MODE_SEL);
            cmp8("period", 8'h01, {7'h0, bit_period === t && baud_locked});
        end else begin
            cmp8("halted", 8'h01, {7'h0, halted && !tx_valid && !baud_locked});
        end
        cmp8("user_boot", {7'h0, bp}, {7'h0, user_boot});
        $display("baud_run done");
    endtask : baud_run

    // A bad index of 15 leaves every password byte correct.
    task automatic pw_frame(input logic [7:0] cmd, input logic [3:0] bad,
                            input logic [7:0] ckoff, input logic e, input logic [7:0] exp);
        logic [7:0] s, b;
        s = 8'h00;
        put_rx(cmd, 1'b0);
        get_tx(cmd);
        for (int k = 0; k < 12; k++) begin
            b = 8'hA0 + k[7:0] + ((k[3:0] == bad) ? 8'h01 : 8'h00);
            s = s + b;
            put_rx(b, e && k == 3);
        end
        put_rx(8'h00 - s + ckoff, 1'b0);
        get_tx(exp);
        $display("pw_frame %h done", cmd);
    endtask : pw_frame

    task automatic busy_run();
        @(posedge clk) flash_busy <= 1'b1;
        repeat (3) @(posedge clk);
        cmp8("ram_exec", 8'h01, {7'h0, ram_exec});
        cmp8("irq_hold", {7'h0, boot_pin}, {7'h0, irq_hold});
        flash_busy <= 1'b0;
        $display("busy_run done");
    endtask : busy_run

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: frames first good, then each error path but the weak password, then a reset
    // into normal mode with a rate too fast to accept.
    initial begin
        baud_run(T, 1'b1);
        pw_frame(CMD_PROT, 4'hF, 8'h00, 1'b0, 8'h60);
        pw_frame(CMD_RAM, 4'h0, 8'h00, 1'b0, 8'h11);
        pw_frame(CMD_PROT, 4'hB, 8'h00, 1'b0, 8'h61);
        pw_frame(CMD_RAM, 4'hF, 8'h01, 1'b0, 8'h11);
        pw_frame(CMD_PROT, 4'hF, 8'h00, 1'b1, 8'h68);
        put_rx(CMD_INFO, 1'b1);
        get_tx(8'h68);
        put_rx(CMD_INFO, 1'b0);
        get_tx(CMD_INFO);
        put_rx(8'h55, 1'b0);
        get_tx(8'h31);
        busy_run();
        baud_run(600, 1'b0);
        busy_run();
        print_verdict();
    end
endmodule : bpc_boot_front_tb

// >>> bpc_flash_model.sv
/*
 * Behavioural flash read port for the boot front end bench.
 * Assumes one outstanding read, held by fl_rd_req with a steady fl_addr.
 */
`timescale 1ns/1ns
module bpc_flash_model (
    input wire logic clk,
    input wire logic fl_rd_req,
    input wire logic [23:0] fl_addr,
    output logic fl_rd_valid,
    output logic [7:0] fl_rdata
);
    logic [1:0] wait_r = 2'h0;
    logic [7:0] byte_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Password bytes ascend from A0H, so a misordered read is visible.
    assign byte_nxt = (fl_addr[23:8] == 16'h027E) ? 8'hA0 + (fl_addr[7:0] - 8'hF4) : 8'h12;

    // Odd addresses answer slowly; idle data flips so stale bytes never match.
    always_ff @(posedge clk) begin
        fl_rd_valid <= 1'b0;
        fl_rdata <= ~fl_rdata;
        if (fl_rd_req && !fl_rd_valid) begin
            wait_r <= wait_r + 2'h1;
            if (wait_r == (fl_addr[0] ? 2'h3 : 2'h1)) begin
                wait_r <= 2'h0;
                fl_rd_valid <= 1'b1;
                fl_rdata <= byte_nxt;
            end
        end
    end
endmodule : bpc_flash_model

// >>> bpc_pkg.sv
/*
 * Shared constants, state type and check-byte arithmetic of the serial
 * boot front end. Assumes a 125 MHz system clock and byte-wide flash reads.
 */
package bpc_pkg;

    // Clock period and link timing.
    localparam int CLK_NS = 8;
    localparam int BIT_MIN_NS = 8681;
    localparam int BIT_MAX_NS = 104167;
    localparam int BIT_MIN_CYC = (BIT_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int BIT_MAX_CYC = BIT_MAX_NS / CLK_NS;
    localparam int TMR_W = 20;
    localparam int EDGE_B_BITS = 2;
    localparam int EDGE_C_BITS = 4;
    localparam int EDGE_D_BITS = 9;
    localparam int SYNC_SETTLE = 3;

    // Frame bytes and acknowledge codes.
    localparam logic [7:0] MODE_SEL = 8'h86;
    localparam logic [7:0] CMD_RAM = 8'h10;
    localparam logic [7:0] CMD_SUM = 8'h20;
    localparam logic [7:0] CMD_INFO = 8'h30;
    localparam logic [7:0] CMD_ERASE = 8'h40;
    localparam logic [7:0] CMD_PROT = 8'h60;
    localparam logic [3:0] ACK_RXERR = 4'h8;
    localparam logic [3:0] ACK_BAD = 4'h1;
    localparam logic [3:0] CMD_HI_RST = 4'h0;

    // Flash layout.
    localparam logic [23:0] PW_BASE = 24'h027EF4;
    localparam logic [23:0] VEC_BASE = 24'h027F00;
    localparam logic [23:0] FLASH_BASE = 24'h010000;
    localparam logic [16:0] FLASH_BYTES = 17'h18000;
    localparam logic [3:0] PW_LEN = 4'hC;
    localparam logic [3:0] VEC_LEN = 4'h3;
    localparam logic [7:0] BLANK = 8'hFF;

    typedef enum logic [9:0] {
        ST_BAUD  = 10'h001,
        ST_HALT  = 10'h002,
        ST_CMD   = 10'h004,
        ST_SEND  = 10'h008,
        ST_PWRD  = 10'h010,
        ST_PWRX  = 10'h020,
        ST_SUMRD = 10'h040,
        ST_SUMHI = 10'h080,
        ST_SUMLO = 10'h100,
        ST_SUMCK = 10'h200
    } bpc_state_t;

    // Byte sum that drops the carry.
    function automatic logic [7:0] ck_add(input logic [7:0] a, input logic [7:0] b);
        ck_add = a + b;
    endfunction : ck_add

    // Two's complement of a running byte sum.
    function automatic logic [7:0] ck_neg(input logic [7:0] s);
        ck_neg = 8'h00 - s;
    endfunction : ck_neg

endpackage : bpc_pkg
